// ---- hw/timer_defines.svh ----
// Purpose: Offsets, field positions, codes and reset values of the timer pair
// Assumes: 8-bit APB byte addresses, one 32-bit word per register
// Notes: Definitions only, shared by the timer top and its clock selector
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TMR_OFS_FIRST_CTL 8'h00
`define TMR_OFS_SECOND_CTL 8'h04
`define TMR_OFS_LOW_REF 8'h08
`define TMR_OFS_HIGH_REF 8'h0C
`define TMR_OFS_LOW_CNT 8'h10
`define TMR_OFS_HIGH_CNT 8'h14
`define TMR_OFS_STATUS 8'h18

// ----------------------------------------------------------------
// Control field positions and codes
// ----------------------------------------------------------------
`define TMR_CTL_CASCADE 7
`define TMR_CTL_MODE_HI 6
`define TMR_CTL_MODE_LO 5
`define TMR_CTL_CLEAR 4
`define TMR_CTL_CS_HI 3
`define TMR_CTL_CS_LO 0
`define TMR_CS_STOP 4'h0
`define TMR_CS_EXT_RISE 4'h5
`define TMR_CS_EXT_FALL 4'h6
`define TMR_CS_SUB 4'h7
// Log2 of the divider, one nibble per code 1000..1111
`define TMR_FIRST_DIV_LOG 32'h1234579B
`define TMR_SECOND_DIV_LOG 32'hA8643210

// ----------------------------------------------------------------
// Status bits and reset values
// ----------------------------------------------------------------
`define TMR_ST_FIRST_MATCH 0
`define TMR_ST_FIRST_OVF 1
`define TMR_ST_SECOND_MATCH 2
`define TMR_ST_SECOND_OVF 3
`define TMR_CTL_RESET 8'h00
`define TMR_REF_RESET 8'h00
`define TMR_CNT_RESET 8'h00
`define TMR_TOP16 16'hFFFF
`define TMR_TOP8 16'h00FF

`endif

// ---- hw/timer_pkg.sv ----
// Purpose: Types shared by the timer pair
// Assumes: Constants come from timer_defines.svh
// Notes: Mode codes are the two-bit control mode field
`default_nettype none

package timer_pkg;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_INTERVAL = 2'b00,
    MODE_PWM = 2'b01,
    MODE_CAP_RISE = 2'b10,
    MODE_CAP_FALL = 2'b11
  } mode_t;

  // One counting step: new count and the events it raised
  typedef struct packed {
    logic [15:0] cnt;
    logic reload;
    logic match;
    logic ovf;
    logic cap;
  } step_t;

endpackage : timer_pkg

`default_nettype wire

// ---- hw/timer_clock_select.sv ----
// Purpose: Timer clock source: prescaled system clock, sub clock or external clock
// Assumes: Pins are asynchronous to sys_clk
// Notes: Emits a one-cycle tick per timer clock
`include "timer_defines.svh"
`default_nettype none

module timer_clock_select #(
  parameter logic [31:0] DIV_LOG_TABLE = `TMR_FIRST_DIV_LOG,
  parameter int DIV_W = 11
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [3:0] clockSelect,
  input wire logic extClockIn,
  input wire logic subClockIn,
  output logic tick
);

  logic [DIV_W-1:0] divCnt;
  logic [2:0] extSync;
  logic [2:0] subSync;
  logic extLevel;
  logic subLevel;
  logic extRise;
  logic extFall;
  logic subRise;
  logic [DIV_W-1:0] mask;

  // Low k bits all ones once every 2^k cycles
  function automatic logic [DIV_W-1:0] divMask(input logic [3:0] k);
    logic [DIV_W:0] full;
    full = ({{DIV_W{1'b0}}, 1'b1} << k) - 1'b1;
    return full[DIV_W-1:0];
  endfunction : divMask

  // ----------------------------------------------------------------
  // Pin synchronisers, level taken when second and third agree
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      extSync <= 3'h0;
      subSync <= 3'h0;
      extLevel <= 1'b0;
      subLevel <= 1'b0;
    end
    else
    begin
      extSync <= {extSync[1:0], extClockIn};
      subSync <= {subSync[1:0], subClockIn};
      if (extSync[1] == extSync[2])
        extLevel <= extSync[2];
      if (subSync[1] == subSync[2])
        subLevel <= subSync[2];
    end
  end

  assign extRise = (extSync[1] == extSync[2]) & extSync[2] & ~extLevel;
  assign extFall = (extSync[1] == extSync[2]) & ~extSync[2] & extLevel;
  assign subRise = (subSync[1] == subSync[2]) & subSync[2] & ~subLevel;
  assign mask = divMask(DIV_LOG_TABLE[{clockSelect[2:0], 2'b00} +: 4]);

  // Free-running divider shared by every prescale tap
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      divCnt <= '0;
    else
      divCnt <= divCnt + 1'b1;
  end

  // Source multiplexer; unused codes give no tick
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      tick <= 1'b0;
    else
      case (clockSelect)
        `TMR_CS_STOP: tick <= 1'b0;
        `TMR_CS_EXT_RISE: tick <= extRise;
        `TMR_CS_EXT_FALL: tick <= extFall;
        `TMR_CS_SUB: tick <= subRise;
        default: tick <= clockSelect[3] & ((divCnt & mask) == mask);
      endcase
  end

endmodule : timer_clock_select

`default_nettype wire

// ---- hw/cascadable_timer_pair.sv ----
// Purpose: Second 8-bit timer and the 16-bit cascade of both timers, APB slave
// Assumes: Pins asynchronous to sys_clk; software writes references before control
// Notes: First timer counts only while cascade is selected
//
// Notes on behaviour
// R01: 8-bit interval match toggles, flags, clears counter
// R02: 8-bit PWM counter runs free, wraps
// R03: 8-bit PWM out high while reference exceeds count
// R04: Software enables the capture pin interrupt
// R05: 8-bit capture copies count to reference, clears
// R06: 8-bit capture flags every counter overflow
// R07: Buffer loads at start, match, overflow
// R08: Software writes reference before control
// R09: Software sets pin, reference, then control
// R10: Cascade forms 16-bit counter, low then high
// R11: Cascade clock from prescaler, sub, external
// R12: Cascade modes interval, capture, PWM
// R13: 16-bit interval match toggles, flags, clears both
// R14: 16-bit PWM counter runs free, wraps
// R15: 16-bit PWM out high while reference exceeds
// R16: 16-bit capture on rising or falling edge
// R17: 16-bit capture copies both bytes, clears
// R18: 16-bit capture flags first timer overflow
// R19: Cascade buffer loads at start, match, overflow
// R20: Software sets pin, both references, then control
// R21: Second clock select codes stop to 1024
// R22: Mode zero selects interval with toggle
// R23: Compare against buffer, not reference register
// R24: Second timer idle while cascaded
// R25: High byte steps on low byte rollover
//
// The APB register port and the address map were decided locally.
`include "timer_defines.svh"
`default_nettype none

module cascadable_timer_pair (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic first_capture_in,
  input wire logic second_capture_in,
  input wire logic first_ext_clock_in,
  input wire logic second_ext_clock_in,
  input wire logic subClockIn,
  output logic first_toggle_out,
  output logic first_pwm_out,
  output logic second_toggle_out,
  output logic second_pwm_out,
  output logic firstMatchIrq,
  output logic firstOverflowIrq,
  output logic secondMatchIrq,
  output logic secondOverflowIrq
);

  logic [7:0] first_timer_control;
  logic [7:0] second_timer_control;
  logic [7:0] low_reference;
  logic [7:0] high_reference;
  logic [7:0] low_counter;
  logic [7:0] high_counter;
  logic [7:0] lowBuffer;
  logic [7:0] highBuffer;
  logic [3:0] status;
  logic first_counter_clear;
  logic second_counter_clear;
  logic tickFirst;
  logic tickSecond;
  logic [2:0] capSyncFirst;
  logic [2:0] capSyncSecond;
  logic capLevelFirst;
  logic capLevelSecond;
  logic capEdge;
  logic cascade;
  timer_pkg::mode_t modeFirst;
  timer_pkg::mode_t modeSecond;
  timer_pkg::mode_t curMode;
  timer_pkg::step_t st;
  logic [15:0] curCnt;
  logic [15:0] curBuf;
  logic apbSetup;
  logic apbWrite;
  logic mapped;
  logic [31:0] readWord;

  assign cascade = first_timer_control[`TMR_CTL_CASCADE];
  assign modeFirst = timer_pkg::mode_t'(first_timer_control[`TMR_CTL_MODE_HI:`TMR_CTL_MODE_LO]);
  assign modeSecond = timer_pkg::mode_t'(second_timer_control[`TMR_CTL_MODE_HI:`TMR_CTL_MODE_LO]);

  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  // R11: cascade clock select
  timer_clock_select #(.DIV_LOG_TABLE(`TMR_FIRST_DIV_LOG), .DIV_W(11)) firstClock (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clockSelect(first_timer_control[`TMR_CTL_CS_HI:`TMR_CTL_CS_LO]),
    .extClockIn(first_ext_clock_in),
    .subClockIn(subClockIn),
    .tick(tickFirst)
  );

  // R21: second clock select
  timer_clock_select #(.DIV_LOG_TABLE(`TMR_SECOND_DIV_LOG), .DIV_W(11)) secondClock (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clockSelect(second_timer_control[`TMR_CTL_CS_HI:`TMR_CTL_CS_LO]),
    .extClockIn(second_ext_clock_in),
    .subClockIn(subClockIn),
    .tick(tickSecond)
  );

  // ----------------------------------------------------------------
  // Capture pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      capSyncFirst <= 3'h0;
      capSyncSecond <= 3'h0;
      capLevelFirst <= 1'b0;
      capLevelSecond <= 1'b0;
    end
    else
    begin
      capSyncFirst <= {capSyncFirst[1:0], first_capture_in};
      capSyncSecond <= {capSyncSecond[1:0], second_capture_in};
      if (capSyncFirst[1] == capSyncFirst[2])
        capLevelFirst <= capSyncFirst[2];
      if (capSyncSecond[1] == capSyncSecond[2])
        capLevelSecond <= capSyncSecond[2];
    end
  end

  // Edge of the agreed level; mode code picks the polarity
  function automatic logic capEdgeOf(input logic [2:0] sync, input logic level,
                                     input timer_pkg::mode_t mode);
    logic agreed;
    agreed = (sync[1] == sync[2]);
    if (mode == timer_pkg::MODE_CAP_FALL)
      return agreed & ~sync[2] & level;
    return agreed & sync[2] & ~level;
  endfunction : capEdgeOf

  // R16: edge polarity select
  assign capEdge = cascade ? capEdgeOf(capSyncFirst, capLevelFirst, modeFirst)
                           : capEdgeOf(capSyncSecond, capLevelSecond, modeSecond);

  // ----------------------------------------------------------------
  // Counting engine, shared by 8-bit and 16-bit widths
  // ----------------------------------------------------------------
  function automatic timer_pkg::step_t stepCounter(input timer_pkg::mode_t mode,
    input logic start, input logic cap, input logic tick,
    input logic [15:0] cnt, input logic [15:0] buff, input logic [15:0] top);
    timer_pkg::step_t s;
    s = '{cnt: cnt, reload: 1'b0, match: 1'b0, ovf: 1'b0, cap: 1'b0};
    if (start)
    begin
      s.cnt = '0;
      s.reload = 1'b1;
    end
    else if (mode[1] && cap)
    begin
      s.cap = 1'b1;
      s.cnt = '0;
    end
    else if (tick)
    begin
      if (!mode[1] && cnt == buff)
      begin
        s.match = 1'b1;
        s.reload = 1'b1;
      end
      if (mode == timer_pkg::MODE_INTERVAL && cnt == buff)
        s.cnt = '0;
      else if (cnt == top)
      begin
        s.ovf = 1'b1;
        s.reload = 1'b1;
        s.cnt = '0;
      end
      else
        s.cnt = cnt + 16'h0001;
    end
    return s;
  endfunction : stepCounter

  // R10: low byte below high byte
  assign curCnt = cascade ? {high_counter, low_counter} : {8'h00, high_counter};
  // R23: compare against the buffer
  assign curBuf = cascade ? {highBuffer, lowBuffer} : {8'h00, highBuffer};
  // R12: cascade mode from first control
  assign curMode = cascade ? modeFirst : modeSecond;
  // R01: 8-bit interval match clears
  // R02: 8-bit PWM free run
  // R13: 16-bit interval match clears
  // R14: 16-bit PWM free run
  // R22: mode zero is interval
  assign st = stepCounter(curMode, cascade ? first_counter_clear : second_counter_clear,
    capEdge, cascade ? tickFirst : tickSecond, curCnt, curBuf,
    cascade ? `TMR_TOP16 : `TMR_TOP8);

  // R25: carry into high byte
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      low_counter <= `TMR_CNT_RESET;
      high_counter <= `TMR_CNT_RESET;
    end
    else if (cascade)
    begin
      low_counter <= st.cnt[7:0];
      high_counter <= st.cnt[15:8];
    end
    else
      high_counter <= st.cnt[7:0];
  end

  // R07: buffer load on events
  // R19: both bytes reload
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      lowBuffer <= `TMR_REF_RESET;
      highBuffer <= `TMR_REF_RESET;
    end
    else if (st.reload)
    begin
      highBuffer <= high_reference;
      if (cascade)
        lowBuffer <= low_reference;
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs and event pulses
  // ----------------------------------------------------------------
  // R24: second timer quiet in cascade
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      first_toggle_out <= 1'b0;
      second_toggle_out <= 1'b0;
      first_pwm_out <= 1'b0;
      second_pwm_out <= 1'b0;
      firstMatchIrq <= 1'b0;
      firstOverflowIrq <= 1'b0;
      secondMatchIrq <= 1'b0;
      secondOverflowIrq <= 1'b0;
    end
    else
    begin
      if (st.match && curMode == timer_pkg::MODE_INTERVAL)
      begin
        if (cascade)
          first_toggle_out <= ~first_toggle_out;
        else
          second_toggle_out <= ~second_toggle_out;
      end
      // R03: 8-bit duty compare
      second_pwm_out <= !cascade && modeSecond == timer_pkg::MODE_PWM && curBuf > curCnt;
      // R15: 16-bit duty compare
      first_pwm_out <= cascade && modeFirst == timer_pkg::MODE_PWM && curBuf > curCnt;
      firstMatchIrq <= cascade & st.match;
      // R18: 16-bit overflow flag
      firstOverflowIrq <= cascade & st.ovf;
      secondMatchIrq <= ~cascade & st.match;
      // R06: 8-bit overflow flag
      secondOverflowIrq <= ~cascade & st.ovf;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, answers in the second access cycle
  // ----------------------------------------------------------------
  assign apbSetup = psel & penable & ~pready;
  assign apbWrite = psel & penable & pready & pwrite;

  always_comb
  begin
    mapped = 1'b1;
    readWord = 32'h0000_0000;
    case (paddr)
      `TMR_OFS_FIRST_CTL: readWord[7:0] = first_timer_control;
      `TMR_OFS_SECOND_CTL: readWord[7:0] = second_timer_control;
      `TMR_OFS_LOW_REF: readWord[7:0] = low_reference;
      `TMR_OFS_HIGH_REF: readWord[7:0] = high_reference;
      `TMR_OFS_LOW_CNT: readWord[7:0] = low_counter;
      `TMR_OFS_HIGH_CNT: readWord[7:0] = high_counter;
      `TMR_OFS_STATUS: readWord[3:0] = status;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= apbSetup;
      pslverr <= apbSetup & ~mapped;
      if (apbSetup)
        prdata <= pwrite ? 32'h0000_0000 : readWord;
    end
  end

  // Control writes; the clear bit only starts and reads back zero
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      first_timer_control <= `TMR_CTL_RESET;
      second_timer_control <= `TMR_CTL_RESET;
      first_counter_clear <= 1'b0;
      second_counter_clear <= 1'b0;
    end
    else
    begin
      first_counter_clear <= apbWrite && paddr == `TMR_OFS_FIRST_CTL && pwdata[`TMR_CTL_CLEAR];
      second_counter_clear <= apbWrite && paddr == `TMR_OFS_SECOND_CTL
                              && pwdata[`TMR_CTL_CLEAR];
      if (apbWrite && paddr == `TMR_OFS_FIRST_CTL)
        first_timer_control <= pwdata[7:0] & ~(8'h01 << `TMR_CTL_CLEAR);
      if (apbWrite && paddr == `TMR_OFS_SECOND_CTL)
        second_timer_control <= pwdata[7:0] & ~(8'h01 << `TMR_CTL_CLEAR);
    end
  end

  // R05: 8-bit capture into reference
  // R17: both bytes captured
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      low_reference <= `TMR_REF_RESET;
      high_reference <= `TMR_REF_RESET;
    end
    else if (st.cap)
    begin
      high_reference <= high_counter;
      if (cascade)
        low_reference <= low_counter;
    end
    else if (apbWrite)
    begin
      if (paddr == `TMR_OFS_LOW_REF)
        low_reference <= pwdata[7:0];
      if (paddr == `TMR_OFS_HIGH_REF)
        high_reference <= pwdata[7:0];
    end
  end

  // Sticky event bits, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      status <= 4'h0;
    else
      status <= (status & ~((apbWrite && paddr == `TMR_OFS_STATUS) ? pwdata[3:0] : 4'h0))
                | {secondOverflowIrq, secondMatchIrq, firstOverflowIrq, firstMatchIrq};
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_tick8(timer_pkg::mode_t m);
    !cascade && modeSecond == m && tickSecond && !second_counter_clear;
  endsequence

  sequence s_tick16(timer_pkg::mode_t m);
    cascade && modeFirst == m && tickFirst && !first_counter_clear;
  endsequence

  property p_interval8;
    @(posedge sys_clk) disable iff (!reset_n)
    s_tick8(timer_pkg::MODE_INTERVAL) ##0 high_counter == highBuffer |=>
      high_counter == 8'h00 && secondMatchIrq && second_toggle_out != $past(second_toggle_out);
  endproperty
  a_interval8: assert property (p_interval8) else $error("interval match missed"); // R01

  property p_pwm8run;
    @(posedge sys_clk) disable iff (!reset_n)
    s_tick8(timer_pkg::MODE_PWM) ##0 high_counter != 8'hFF |=>
      high_counter == $past(high_counter) + 8'h01;
  endproperty
  a_pwm8run: assert property (p_pwm8run) else $error("pwm counter not free running"); // R02

  property p_pwm8out;
    @(posedge sys_clk) disable iff (!reset_n)
    !cascade && modeSecond == timer_pkg::MODE_PWM |=>
      second_pwm_out == ($past(highBuffer) > $past(high_counter));
  endproperty
  a_pwm8out: assert property (p_pwm8out) else $error("pwm level wrong"); // R03

  property p_capture8;
    @(posedge sys_clk) disable iff (!reset_n)
    !cascade && modeSecond[1] && capEdge && !second_counter_clear |=>
      high_reference == $past(high_counter) && high_counter == 8'h00;
  endproperty
  a_capture8: assert property (p_capture8) else $error("capture not taken"); // R05

  property p_ovf8;
    @(posedge sys_clk) disable iff (!reset_n)
    s_tick8(timer_pkg::MODE_CAP_RISE) ##0 !capEdge && high_counter == 8'hFF |=>
      secondOverflowIrq ##1 !secondOverflowIrq;
  endproperty
  a_ovf8: assert property (p_ovf8) else $error("overflow pulse wrong"); // R06

  property p_start;
    @(posedge sys_clk) disable iff (!reset_n)
    !cascade && second_counter_clear |=> highBuffer == $past(high_reference)
      && high_counter == 8'h00;
  endproperty
  a_start: assert property (p_start) else $error("start did not load buffer"); // R07

  property p_interval16;
    @(posedge sys_clk) disable iff (!reset_n)
    s_tick16(timer_pkg::MODE_INTERVAL) ##0 {high_counter, low_counter} == curBuf |=>
      {high_counter, low_counter} == 16'h0000 && firstMatchIrq;
  endproperty
  a_interval16: assert property (p_interval16) else $error("16-bit match missed"); // R13

  property p_capture16;
    @(posedge sys_clk) disable iff (!reset_n)
    cascade && modeFirst[1] && capEdge && !first_counter_clear |=>
      {high_reference, low_reference} == $past({high_counter, low_counter})
      && {high_counter, low_counter} == 16'h0000;
  endproperty
  a_capture16: assert property (p_capture16) else $error("16-bit capture wrong"); // R17

  property p_quiet;
    @(posedge sys_clk) disable iff (!reset_n)
    cascade [*2] |-> !secondMatchIrq && !secondOverflowIrq;
  endproperty
  a_quiet: assert property (p_quiet) else $error("second timer active in cascade"); // R24

  property p_carry;
    @(posedge sys_clk) disable iff (!reset_n)
    s_tick16(timer_pkg::MODE_PWM) ##0 low_counter != 8'hFF |=>
      high_counter == $past(high_counter);
  endproperty
  a_carry: assert property (p_carry) else $error("high byte stepped early"); // R25

endmodule : cascadable_timer_pair

`default_nettype wire

// ---- sim/pin_model.sv ----
// Purpose: Board side of the timer pair: clock and capture pins
// Assumes: Every level is held 4 sys_clk cycles, above the 2-cycle minimum
// Notes: Clock pins stand still low between bursts, as a real source would
`default_nettype none

module pin_model (
  input wire logic sys_clk,
  output logic firstCap,
  output logic secondCap,
  output logic secondExt,
  output logic subClk
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    firstCap = 1'b0;
    secondCap = 1'b0;
    secondExt = 1'b0;
    subClk = 1'b0;
  end

  // Hold a level long enough for the 3-stage synchroniser
  task automatic hold4;
    repeat (4) @(posedge sys_clk);
  endtask : hold4

  // Burst of n clock pulses on the sub clock (sel 0) or external clock
  task automatic burst(input int sel, input int n);
    for (int i = 0; i < n; i++)
    begin
      if (sel == 0) subClk <= 1'b1; else secondExt <= 1'b1;
      hold4();
      if (sel == 0) subClk <= 1'b0; else secondExt <= 1'b0;
      hold4();
    end
  endtask : burst

  // Move a capture pin to a new level
  task automatic setCap(input int sel, input logic v);
    if (sel == 0) firstCap <= v; else secondCap <= v;
    hold4();
  endtask : setCap
endmodule : pin_model

`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: Self-checking bench of the cascadable timer pair
// Assumes: Three-cycle APB access with one wait state, one-cycle event pulses
// Notes: Gaps between pulses are counted in sys_clk cycles
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, er, firstCap, secondCap, secondExt, subClk;
  logic [3:0] irqs;
  logic [1:0] tog;
  logic secondPwm, firstPwm, togHeld;
  int err_total = 0, check_count = 0, gap, hi;

  cascadable_timer_pair u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .first_capture_in(firstCap),
    .second_capture_in(secondCap), .first_ext_clock_in(secondExt),
    .second_ext_clock_in(secondExt), .subClockIn(subClk), .first_toggle_out(tog[0]),
    .first_pwm_out(firstPwm), .second_toggle_out(tog[1]), .second_pwm_out(secondPwm),
    .firstMatchIrq(irqs[0]), .firstOverflowIrq(irqs[1]), .secondMatchIrq(irqs[2]),
    .secondOverflowIrq(irqs[3]));
  pin_model u_pins (.sys_clk(sys_clk), .firstCap(firstCap), .secondCap(secondCap),
    .secondExt(secondExt), .subClk(subClk));

  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task automatic test_done;
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; pready and the answer are taken at the same rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      err_total++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask : rdchk

  // Bounded wait for an event pulse; gap is cycles waited minus one
  task automatic wait_irq(input int sel);
    for (gap = 0; gap < 3000; gap++)
    begin
      @(negedge sys_clk);
      if (irqs[sel] === 1'b1) return;
    end
    err_total++;
    test_done();
  endtask : wait_irq

  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 7; a++) rdchk(8'(4 * a), 32'h00000000);
    apb(1'b0, 8'h1C, 32'h00000000);
    check({31'h00000000, er}, 32'h00000001);
    // reference before control; 8-bit interval at sys_clk/1
    apb(1'b1, 8'h0C, 32'h00000002);
    apb(1'b1, 8'h04, 32'h00000018);
    wait_irq(2);
    check({30'h00000000, tog}, 32'h00000002);
    wait_irq(2);
    check(32'(gap), 32'h00000002);
    check({30'h00000000, tog}, 32'h00000000);
    apb(1'b1, 8'h04, 32'h00000000);
    rdchk(8'h18, 32'h00000004);
    apb(1'b1, 8'h18, 32'h0000000F);
    rdchk(8'h18, 32'h00000000);
    // Toggle level left by the stopped 8-bit timer must survive cascade
    togHeld = tog[1];
    // reference, then control; 8-bit PWM
    apb(1'b1, 8'h0C, 32'h00000040);
    apb(1'b1, 8'h04, 32'h00000038);
    wait_irq(3);
    wait_irq(3);
    check(32'(gap), 32'h000000FF);
    hi = 0;
    repeat (256) @(negedge sys_clk) hi += (secondPwm === 1'b1);
    check(32'(hi), 32'h00000040);
    // 8-bit capture on rising edge, external clock
    apb(1'b1, 8'h04, 32'h00000055);
    u_pins.burst(1, 9);
    repeat (8) @(posedge sys_clk);
    u_pins.setCap(1, 1'b1);
    repeat (4) @(posedge sys_clk);
    rdchk(8'h0C, 32'h00000009);
    rdchk(8'h14, 32'h00000000);
    apb(1'b1, 8'h04, 32'h00000000);
    // both references then control; 16-bit interval at /2
    apb(1'b1, 8'h08, 32'h00000004);
    apb(1'b1, 8'h0C, 32'h00000001);
    apb(1'b1, 8'h00, 32'h0000009F);
    wait_irq(0);
    wait_irq(0);
    check(32'(gap), 32'h00000209);
    check({30'h00000000, tog}, {30'h00000000, togHeld, 1'b0});
    rdchk(8'h18, 32'h0000000D);
    // 16-bit capture on the falling edge, counting sub clock pulses
    u_pins.setCap(0, 1'b1);
    apb(1'b1, 8'h00, 32'h000000F7);
    u_pins.burst(0, 5);
    repeat (8) @(posedge sys_clk);
    u_pins.setCap(0, 1'b0);
    repeat (4) @(posedge sys_clk);
    rdchk(8'h08, 32'h00000005);
    rdchk(8'h0C, 32'h00000000);
    rdchk(8'h10, 32'h00000000);
    // both references then control; 16-bit PWM at /2
    apb(1'b1, 8'h08, 32'h00000010);
    apb(1'b1, 8'h0C, 32'h00000000);
    apb(1'b1, 8'h00, 32'h000000BF);
    repeat (4) @(negedge sys_clk);
    check({31'h00000000, firstPwm}, 32'h00000001);
    repeat (64) @(negedge sys_clk);
    check({31'h00000000, firstPwm}, 32'h00000000);
    test_done();
  end
endmodule : tb

`default_nettype wire
